// >>> rtl/cbd_fifo.sv
`timescale 1ns/1ps
module cbd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0]   count_reg, count_next;
  logic          ovalid_reg, ovalid_next;
  logic          push, fetch;

  always_comb begin
    // full at DEPTH words; a 4-bit cast of DEPTH would wrap to zero
    in_ready    = (count_reg != (AW+1)'(DEPTH));
    push        = in_valid && in_ready;
    // fetch into the output register when it is free or being drained
    fetch       = (count_reg != '0) && (!ovalid_reg || out_ready);
    wptr_next   = push ? wptr_reg + AW'(1) : wptr_reg;
    rptr_next   = fetch ? rptr_reg + AW'(1) : rptr_reg;
    count_next  = count_reg + (AW+1)'(push) - (AW+1)'(fetch);
    ovalid_next = fetch ? 1'b1 : (out_ready ? 1'b0 : ovalid_reg);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wptr_reg   <= '0;
      rptr_reg   <= '0;
      count_reg  <= '0;
      ovalid_reg <= 1'b0;
    end else begin
      wptr_reg   <= wptr_next;
      rptr_reg   <= rptr_next;
      count_reg  <= count_next;
      ovalid_reg <= ovalid_next;
    end
  end

  assign out_valid = ovalid_reg;

  cbd_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (push),
    .wr_addr (wptr_reg),
    .wr_data (in_data),
    .rd_en   (fetch),
    .rd_addr (rptr_reg),
    .rd_data (out_data)
  );

  property p_full_refuses;
    @(posedge clk_sys) disable iff (reset)
      (count_reg == (AW+1)'(DEPTH)) |-> !in_ready;
  endproperty
  a_full_refuses: assert property (p_full_refuses)
    else $error("fifo accepts data while full");

endmodule // cbd_fifo

// >>> rtl/cbd_loader.sv
`timescale 1ns/1ps
module cbd_loader (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // scheme and session
  input  wire logic [3:0]                 scheme_select,
  input  wire logic                       jtag_config,
  input  wire logic                       config_enable,
  input  wire logic                       local_update_req,
  // configuration link from host
  input  wire logic                       config_clock,
  input  wire logic [cbd_pkg::DATA_W-1:0] config_data,
  input  wire logic                       config_serial,
  output logic                            data_ready,
  // configuration memory write port
  output logic                            cfg_wr_valid,
  input  wire logic                       cfg_wr_ready,
  output logic [cbd_pkg::ADDR_W-1:0]      cfg_wr_addr,
  output logic [cbd_pkg::DATA_W-1:0]      cfg_wr_data,
  // status
  output logic                            compressed_detected,
  output logic                            decomp_enabled,
  output logic                            local_update_mode,
  output logic                            overflow_error
);

  localparam int unsigned DW = cbd_pkg::DATA_W;
  localparam int unsigned AW = cbd_pkg::ADDR_W;

  function automatic logic is_par_dec(input logic [3:0] sel);
    return sel == cbd_pkg::SEL_PAR_DEC || sel == cbd_pkg::SEL_RSU_PAR_DEC;
  endfunction

  function automatic logic is_aser(input logic [3:0] sel);
    return sel == cbd_pkg::SEL_ASER || sel == cbd_pkg::SEL_ASER_FAST ||
           sel == cbd_pkg::SEL_RSU_ASER || sel == cbd_pkg::SEL_RSU_ASER_FAST;
  endfunction

  function automatic logic is_pser(input logic [3:0] sel);
    return sel == cbd_pkg::SEL_PSER || sel == cbd_pkg::SEL_RSU_PSER;
  endfunction

  function automatic logic is_rsu(input logic [3:0] sel);
    return sel == cbd_pkg::SEL_RSU_PAR || sel == cbd_pkg::SEL_RSU_APAR ||
           sel == cbd_pkg::SEL_RSU_PSER || sel == cbd_pkg::SEL_RSU_PAR_DEC ||
           sel == cbd_pkg::SEL_RSU_ASER || sel == cbd_pkg::SEL_RSU_ASER_FAST;
  endfunction

  // session and link sampling
  logic [3:0]      scheme_reg, scheme_next;
  logic            jtag_reg, jtag_next;
  logic            local_reg, local_next;
  logic            enable_prev_reg;
  logic            cclk_prev_reg;
  logic [1:0]      edge_cnt_reg, edge_cnt_next;
  logic [DW-1:0]   shift_reg, shift_next;
  logic [2:0]      bit_cnt_reg, bit_cnt_next;
  logic            ovf_reg, ovf_next;
  logic            start, cclk_rise, serial_mode, allow_decomp;
  logic            take, fifo_in_valid, fifo_in_ready;
  logic [DW-1:0]   fifo_in_data;

  always_comb begin
    start        = config_enable && !enable_prev_reg;
    cclk_rise    = config_enable && config_clock && !cclk_prev_reg;
    scheme_next  = start ? scheme_select : scheme_reg;
    jtag_next    = start ? jtag_config : jtag_reg;
    // local update only exists for the non-active-serial schemes
    local_next   = start ? (is_rsu(scheme_select) && !is_aser(scheme_select)
                            && local_update_req) : local_reg;
    serial_mode  = is_aser(scheme_reg) || is_pser(scheme_reg);
    // parallel plain mode is fed already expanded by the memory device
    allow_decomp = !jtag_reg &&
                   (serial_mode || is_par_dec(scheme_reg));
    edge_cnt_next = edge_cnt_reg;
    shift_next    = shift_reg;
    bit_cnt_next  = bit_cnt_reg;
    take          = 1'b0;
    fifo_in_data  = config_data;
    if (start) begin
      edge_cnt_next = '0;
      bit_cnt_next  = '0;
    end else if (cclk_rise) begin
      if (serial_mode) begin
        // lsb first, one bit per edge; the word is taken on the eighth edge
        shift_next   = {config_serial, shift_reg[DW-1:1]};
        bit_cnt_next = bit_cnt_reg + 3'h1;
        take         = (bit_cnt_reg == cbd_pkg::SERIAL_LAST_BIT);
        fifo_in_data = {config_serial, shift_reg[DW-1:1]};
      end else if (is_par_dec(scheme_reg)) begin
        // one word per four edges; data is held by the host meanwhile
        take          = (edge_cnt_reg == 2'h0);
        edge_cnt_next = (edge_cnt_reg == cbd_pkg::PAR_DEC_EDGES_M1) ?
                        2'h0 : edge_cnt_reg + 2'h1;
      end else begin
        take = 1'b1;
      end
    end
    fifo_in_valid = take;
    // a word that finds the fifo full is lost; the host watches data_ready
    ovf_next = start ? 1'b0 : (ovf_reg || (take && !fifo_in_ready));
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scheme_reg      <= cbd_pkg::SEL_PAR;
      jtag_reg        <= 1'b0;
      local_reg       <= 1'b0;
      enable_prev_reg <= 1'b0;
      cclk_prev_reg   <= 1'b0;
      edge_cnt_reg    <= '0;
      shift_reg       <= '0;
      bit_cnt_reg     <= '0;
      ovf_reg         <= 1'b0;
    end else begin
      scheme_reg      <= scheme_next;
      jtag_reg        <= jtag_next;
      local_reg       <= local_next;
      enable_prev_reg <= config_enable;
      cclk_prev_reg   <= config_clock;
      edge_cnt_reg    <= edge_cnt_next;
      shift_reg       <= shift_next;
      bit_cnt_reg     <= bit_cnt_next;
      ovf_reg         <= ovf_next;
    end
  end

  // buffer
  logic          fifo_out_valid, fifo_out_ready;
  logic [DW-1:0] fifo_out_data;

  cbd_fifo #(.WIDTH(DW), .DEPTH(cbd_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // expander
  cbd_pkg::cbd_state_type state_reg, state_next;
  logic [6:0]    cnt_reg, cnt_next;
  logic          comp_reg, comp_next;
  logic          wvalid_reg, wvalid_next;
  logic [DW-1:0] wdata_reg, wdata_next;
  logic [AW-1:0] waddr_reg, waddr_next, addr_cnt_reg, addr_cnt_next;
  logic          can_emit, emit;
  logic [DW-1:0] emit_data;

  always_comb begin
    can_emit       = !wvalid_reg || cfg_wr_ready;
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    comp_next      = comp_reg;
    fifo_out_ready = 1'b0;
    emit           = 1'b0;
    emit_data      = fifo_out_data;
    case (state_reg)
      cbd_pkg::CBD_ST_FIRST: begin
        if (fifo_out_valid) begin
          if (allow_decomp && fifo_out_data == cbd_pkg::COMP_MARK) begin
            fifo_out_ready = 1'b1;
            comp_next      = 1'b1;
            state_next     = cbd_pkg::CBD_ST_CTRL;
          end else if (can_emit) begin
            fifo_out_ready = 1'b1;
            emit           = 1'b1;
            state_next     = cbd_pkg::CBD_ST_PASS;
          end
        end
      end
      cbd_pkg::CBD_ST_PASS: begin
        fifo_out_ready = fifo_out_valid && can_emit;
        emit           = fifo_out_valid && can_emit;
      end
      cbd_pkg::CBD_ST_CTRL: begin
        fifo_out_ready = fifo_out_valid;
        if (fifo_out_valid) begin
          cnt_next   = fifo_out_data[6:0];
          state_next = fifo_out_data[cbd_pkg::CTRL_RUN_BIT] ?
                       cbd_pkg::CBD_ST_RUN : cbd_pkg::CBD_ST_LIT;
        end
      end
      cbd_pkg::CBD_ST_RUN: begin
        // runs need no input, so the fifo is not read and fills from the link meanwhile
        emit      = can_emit;
        emit_data = cbd_pkg::FILL_BYTE;
        if (can_emit) begin
          cnt_next   = cnt_reg - 7'h01;
          state_next = (cnt_reg == cbd_pkg::CNT_ZERO) ?
                       cbd_pkg::CBD_ST_CTRL : cbd_pkg::CBD_ST_RUN;
        end
      end
      cbd_pkg::CBD_ST_LIT: begin
        fifo_out_ready = fifo_out_valid && can_emit;
        emit           = fifo_out_valid && can_emit;
        if (emit) begin
          cnt_next   = cnt_reg - 7'h01;
          state_next = (cnt_reg == cbd_pkg::CNT_ZERO) ?
                       cbd_pkg::CBD_ST_CTRL : cbd_pkg::CBD_ST_LIT;
        end
      end
      default: begin
        state_next = cbd_pkg::CBD_ST_FIRST;
      end
    endcase
    wvalid_next   = emit ? 1'b1 : (cfg_wr_ready ? 1'b0 : wvalid_reg);
    wdata_next    = emit ? emit_data : wdata_reg;
    waddr_next    = emit ? addr_cnt_reg : waddr_reg;
    addr_cnt_next = emit ? addr_cnt_reg + AW'(1) : addr_cnt_reg;
    if (start) begin
      state_next    = cbd_pkg::CBD_ST_FIRST;
      comp_next     = 1'b0;
      addr_cnt_next = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg    <= cbd_pkg::CBD_ST_FIRST;
      cnt_reg      <= '0;
      comp_reg     <= 1'b0;
      wvalid_reg   <= 1'b0;
      wdata_reg    <= '0;
      waddr_reg    <= '0;
      addr_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      comp_reg     <= comp_next;
      wvalid_reg   <= wvalid_next;
      wdata_reg    <= wdata_next;
      waddr_reg    <= waddr_next;
      addr_cnt_reg <= addr_cnt_next;
    end
  end

  assign data_ready          = fifo_in_ready;
  assign cfg_wr_valid        = wvalid_reg;
  assign cfg_wr_data         = wdata_reg;
  assign cfg_wr_addr         = waddr_reg;
  assign compressed_detected = comp_reg;
  assign decomp_enabled      = allow_decomp;
  assign local_update_mode   = local_reg;
  assign overflow_error      = ovf_reg;

  // checks
  property p_no_decomp_async;
    @(posedge clk_sys) disable iff (reset)
      (scheme_reg == cbd_pkg::SEL_APAR || jtag_reg) |-> !decomp_enabled;
  endproperty
  a_no_decomp_async: assert property (p_no_decomp_async)
    else $error("expander enabled in asynchronous or boundary-scan load");

  property p_plain_par_raw;
    @(posedge clk_sys) disable iff (reset)
      (scheme_reg == cbd_pkg::SEL_PAR && state_reg == cbd_pkg::CBD_ST_FIRST)
      |=> !compressed_detected;
  endproperty
  a_plain_par_raw: assert property (p_plain_par_raw)
    else $error("plain parallel stream treated as compressed");

  property p_par_dec_spacing;
    @(posedge clk_sys) disable iff (reset)
      (take && is_par_dec(scheme_reg) && !start) |=> !take [*5];
  endproperty
  a_par_dec_spacing: assert property (p_par_dec_spacing)
    else $error("parallel decompression word taken too early");

  property p_pass_unchanged;
    @(posedge clk_sys) disable iff (reset)
      (state_reg == cbd_pkg::CBD_ST_PASS && emit && !start)
      |=> cfg_wr_valid && cfg_wr_data == $past(fifo_out_data);
  endproperty
  a_pass_unchanged: assert property (p_pass_unchanged)
    else $error("uncompressed byte altered");

  property p_detect_mark;
    @(posedge clk_sys) disable iff (reset)
      (state_reg == cbd_pkg::CBD_ST_FIRST && fifo_out_valid && allow_decomp
       && fifo_out_data == cbd_pkg::COMP_MARK && !start)
      |=> compressed_detected && state_reg == cbd_pkg::CBD_ST_CTRL;
  endproperty
  a_detect_mark: assert property (p_detect_mark)
    else $error("compressed stream not recognised");

  sequence s_run_step;
    state_reg == cbd_pkg::CBD_ST_RUN && cfg_wr_ready && !start;
  endsequence
  sequence s_zero_written;
    cfg_wr_valid && cfg_wr_data == cbd_pkg::FILL_BYTE;
  endsequence
  property p_run_every_clock;
    @(posedge clk_sys) disable iff (reset)
      s_run_step |=> s_zero_written;
  endproperty
  a_run_every_clock: assert property (p_run_every_clock)
    else $error("run byte not written in the next cycle");

  property p_aser_no_local;
    @(posedge clk_sys) disable iff (reset)
      is_aser(scheme_reg) |-> !local_update_mode;
  endproperty
  a_aser_no_local: assert property (p_aser_no_local)
    else $error("local update active in active serial scheme");

  property p_par_dec_select;
    @(posedge clk_sys) disable iff (reset)
      (scheme_reg == cbd_pkg::SEL_PAR_DEC && !jtag_reg) |-> decomp_enabled;
  endproperty
  a_par_dec_select: assert property (p_par_dec_select)
    else $error("parallel decompression pattern not honoured");

endmodule // cbd_loader

// >>> rtl/cbd_mem.sv
`timescale 1ns/1ps
module cbd_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock
  input  wire logic                     clk_sys,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // read side, data registered
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] store_reg [DEPTH];

  // no reset: storage content is only read after being written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      store_reg[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= store_reg[rd_addr];
    end
  end

endmodule // cbd_mem

// >>> rtl/cbd_pkg.sv
package cbd_pkg;

  // byte width of the configuration stream
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned ADDR_W     = 24;

  // scheme_select codes
  localparam logic [3:0] SEL_PAR           = 4'h0;
  localparam logic [3:0] SEL_APAR          = 4'h1;
  localparam logic [3:0] SEL_PSER          = 4'h2;
  localparam logic [3:0] SEL_RSU_PAR       = 4'h4;
  localparam logic [3:0] SEL_RSU_APAR      = 4'h5;
  localparam logic [3:0] SEL_RSU_PSER      = 4'h6;
  localparam logic [3:0] SEL_ASER_FAST     = 4'h8;
  localparam logic [3:0] SEL_RSU_ASER_FAST = 4'h9;
  localparam logic [3:0] SEL_PAR_DEC       = 4'hB;
  localparam logic [3:0] SEL_RSU_PAR_DEC   = 4'hC;
  localparam logic [3:0] SEL_ASER          = 4'hD;
  localparam logic [3:0] SEL_RSU_ASER      = 4'hE;

  // stream format
  localparam logic [7:0] COMP_MARK    = 8'hC5;
  localparam int unsigned CTRL_RUN_BIT = 7;
  localparam logic [6:0] CNT_ZERO     = 7'h00;
  localparam logic [7:0] FILL_BYTE    = 8'h00;

  // index of the last config_clock edge of a word, in parallel decompression and in serial mode
  localparam logic [1:0] PAR_DEC_EDGES_M1 = 2'h3;
  localparam logic [2:0] SERIAL_LAST_BIT  = 3'h7;

  typedef enum logic [2:0] {
    CBD_ST_FIRST = 3'b000,
    CBD_ST_PASS  = 3'b001,
    CBD_ST_CTRL  = 3'b010,
    CBD_ST_RUN   = 3'b011,
    CBD_ST_LIT   = 3'b100
  } cbd_state_type;

endpackage

// >>> tb/cbd_host.sv
`timescale 1ns/1ps
module cbd_host (
  // clock
  input  wire logic       clk_sys,
  // link toward the loader
  output logic            config_clock,
  output logic [7:0]      config_data,
  output logic            config_serial,
  input  wire logic       data_ready
);
  // bytes the loader had room for, and how many it lost
  logic [7:0] taken_q[$];
  int         n_drop;

  initial begin
    config_clock  = 1'b0;
    config_data   = 8'h00;
    config_serial = 1'b0;
    n_drop        = 0;
  end

  // mode 0 plain parallel, 1 parallel with expansion, 2 serial lsb first
  task automatic send_byte(input logic [7:0] b, input int mode);
    int   edges;
    int   take;
    logic ok;
    edges = (mode == 0) ? 1 : (mode == 1) ? 4 : 8;
    take  = (mode == 2) ? 7 : 0;
    ok    = 1'b0;
    for (int i = 0; i < edges; i++) begin
      @(posedge clk_sys);
      #1;
      config_data   = (mode == 2) ? ~b : b;
      config_serial = b[i];
      config_clock  = 1'b1;
      @(negedge clk_sys);
      // room is judged as the loader sees it at the taking edge
      if (i == take) ok = data_ready;
      @(posedge clk_sys);
      #1;
      config_clock = 1'b0;
    end
    // released lines show the inverse so a stale value cannot pass
    config_data   = ~b;
    config_serial = ~config_serial;
    if (ok === 1'b1) taken_q.push_back(b);
    else n_drop++;
  endtask
endmodule // cbd_host

// >>> tb/config_bitstream_decompress_tb.sv
`timescale 1ns/1ps
module config_bitstream_decompress_tb;
  localparam logic [3:0] CODES [12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6,
                                        4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE};
  logic                       clk_sys;
  logic                       reset;
  logic [3:0]                 scheme_select;
  logic                       jtag_config;
  logic                       config_enable;
  logic                       local_update_req;
  logic                       config_clock;
  logic [cbd_pkg::DATA_W-1:0] config_data;
  logic                       config_serial;
  logic                       data_ready;
  logic                       cfg_wr_valid;
  logic                       cfg_wr_ready;
  logic [cbd_pkg::ADDR_W-1:0] cfg_wr_addr;
  logic [cbd_pkg::DATA_W-1:0] cfg_wr_data;
  logic                       compressed_detected;
  logic                       decomp_enabled;
  logic                       local_update_mode;
  logic                       overflow_error;
  int                         num_errors;
  int                         n_tests;
  int                         ready_mode;
  logic [7:0]                 src_q[$];
  logic [7:0]                 exp_q[$];
  logic [7:0]                 got_q[$];

  cbd_loader dut_u (
    .clk_sys(clk_sys), .reset(reset), .scheme_select(scheme_select),
    .jtag_config(jtag_config), .config_enable(config_enable),
    .local_update_req(local_update_req), .config_clock(config_clock),
    .config_data(config_data), .config_serial(config_serial),
    .data_ready(data_ready), .cfg_wr_valid(cfg_wr_valid),
    .cfg_wr_ready(cfg_wr_ready), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .compressed_detected(compressed_detected),
    .decomp_enabled(decomp_enabled), .local_update_mode(local_update_mode),
    .overflow_error(overflow_error)
  );

  cbd_host host_u (
    .clk_sys(clk_sys), .config_clock(config_clock),
    .config_data(config_data), .config_serial(config_serial),
    .data_ready(data_ready)
  );

  always #20 clk_sys = ~clk_sys;

  // 1 always ready, 2 stalled, otherwise random stalls
  always @(posedge clk_sys) begin
    #1;
    if (ready_mode == 1) cfg_wr_ready = 1'b1;
    else if (ready_mode == 2) cfg_wr_ready = 1'b0;
    else cfg_wr_ready = ($urandom % 4 != 0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  always @(posedge clk_sys) begin
    if (cfg_wr_valid === 1'b1 && cfg_wr_ready === 1'b1) begin
      check(32'(cfg_wr_addr), 32'(got_q.size()));
      got_q.push_back(cfg_wr_data);
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // runs stay short so random stalls never overrun the buffer
  task automatic gen(input bit comp);
    int n;
    src_q.delete();
    if (comp) begin
      src_q.push_back(cbd_pkg::COMP_MARK);
      repeat (6) begin
        n = $urandom % 4;
        if ($urandom % 2) src_q.push_back(8'h80 | 8'(n));
        else begin
          src_q.push_back(8'(n));
          repeat (n + 1) src_q.push_back(8'($urandom));
        end
      end
    end else begin
      repeat (24) src_q.push_back(8'($urandom));
      if (src_q[0] == cbd_pkg::COMP_MARK) src_q[0] = 8'h3C;
    end
  endtask

  task automatic expand(input bit allow);
    logic [7:0] q[$];
    logic [7:0] c;
    int         i;
    q = host_u.taken_q;
    exp_q.delete();
    if (allow && q.size() > 0 && q[0] == cbd_pkg::COMP_MARK) begin
      i = 1;
      while (i < q.size()) begin
        c = q[i];
        i++;
        repeat (int'(c[6:0]) + 1) begin
          if (c[7]) exp_q.push_back(cbd_pkg::FILL_BYTE);
          else if (i < q.size()) begin
            exp_q.push_back(q[i]);
            i++;
          end
        end
      end
    end else exp_q = q;
  endtask

  task automatic run_session(input logic [3:0] code, input logic jt,
                             input logic req, input bit comp, input int rm);
    int hm;
    bit allow;
    int w;
    gen(comp);
    got_q.delete();
    host_u.taken_q.delete();
    host_u.n_drop = 0;
    hm = (!code[3] && !code[1]) ? 0 : (code == 4'hB || code == 4'hC) ? 1 : 2;
    allow = !jt && hm != 0;
    @(negedge clk_sys);
    ready_mode = rm;
    @(posedge clk_sys);
    #1;
    scheme_select = code;
    jtag_config = jt;
    local_update_req = req;
    @(posedge clk_sys);
    #1;
    config_enable = 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (src_q[i]) host_u.send_byte(src_q[i], hm);
    if (rm == 2) begin
      check(32'(overflow_error), 32'h1);
      check(32'(data_ready), 32'h0);
      @(negedge clk_sys);
      ready_mode = 1;
    end
    expand(allow);
    w = 0;
    while (got_q.size() < exp_q.size() && w < 2000) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (4) @(posedge clk_sys);
    #1;
    check(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size()) check(32'(got_q[i]), 32'(exp_q[i]));
    check(32'(compressed_detected), 32'(allow && comp));
    check(32'(decomp_enabled), 32'(allow));
    if (rm == 1) check(32'(w <= 16), 32'h1);
    if (rm != 2) check(32'(overflow_error), 32'h0);
    check(32'(data_ready), 32'h1);
    if (code inside {4'h8, 4'h9, 4'hD, 4'hE})
      check(32'(local_update_mode), 32'h0);
    else if (code inside {4'h4, 4'h5, 4'h6, 4'hC})
      check(32'(local_update_mode), 32'(req));
    else
      check(32'(local_update_mode), 32'h0);
    config_enable = 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    scheme_select = 4'h0;
    jtag_config = 1'b0;
    config_enable = 1'b0;
    local_update_req = 1'b0;
    cfg_wr_ready = 1'b0;
    ready_mode = 1;
    num_errors = 0;
    n_tests = 0;
    void'($urandom(11769));
    repeat (10) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    // every scheme code with a compressed stream, alternately always ready and with random stalls
    foreach (CODES[i])
      run_session(CODES[i], 1'b0, 1'($urandom % 2), 1'b1,
                  (i % 2 == 0) ? 1 : 3);
    run_session(4'h2, 1'b1, 1'b0, 1'b1, 1);
    run_session(4'hB, 1'b0, 1'b0, 1'b0, 3);
    run_session(4'hD, 1'b0, 1'b1, 1'b0, 3);
    // stalled memory: buffer fills, later words are lost
    run_session(4'h0, 1'b0, 1'b0, 1'b0, 2);
    run_session(4'h0, 1'b0, 1'b0, 1'b1, 1);
    stop_test();
  end

  // roughly twenty-five times the expected length of all sessions
  initial begin
    #(40 * 80000);
    num_errors++;
    stop_test();
  end
endmodule // config_bitstream_decompress_tb
